//--- src/fwpt_pkg.sv
package fwpt_pkg;
  localparam int ADDR_W = 18;
  localparam int CLK_MHZ = 10;
  localparam int REG_AW = 8;
  localparam int T_SUSP_LAT_US = 30;
  localparam int T_RES_SUSP_US = 20;
  localparam int T_VSL_US = 70;
  localparam int T_PROG_TYP_US = 2000;
  localparam int T_PROG_MAX_US = 3000;
  localparam int T_ERASE_TYP_US = 8000;
  localparam int T_ERASE_MAX_US = 20000;
  // Longest times round down, least times round up
  localparam int SUSP_LAT_CYC = (T_SUSP_LAT_US * CLK_MHZ);
  localparam int RES_SUSP_CYC = (T_RES_SUSP_US * CLK_MHZ);
  localparam int VSL_CYC = (T_VSL_US * CLK_MHZ);
  localparam int PROG_TYP_CYC = (T_PROG_TYP_US * CLK_MHZ);
  localparam int PROG_MAX_CYC = (T_PROG_MAX_US * CLK_MHZ);
  localparam int ERASE_TYP_CYC = (T_ERASE_TYP_US * CLK_MHZ);
  localparam int ERASE_MAX_CYC = (T_ERASE_MAX_US * CLK_MHZ);
  localparam logic [REG_AW-1:0] REG_STATUS_OFS = 8'h00;
  localparam logic [REG_AW-1:0] REG_EVENT_OFS = 8'h04;
  localparam int ST_BUSY_BIT = 0;
  localparam int ST_WEL_BIT = 1;
  localparam int ST_BP_LSB = 2;
  localparam int ST_LOCK_LSB = 7;
  localparam int ST_CMP_BIT = 9;
  localparam int ST_SUS_BIT = 10;
  localparam int EV_READY_BIT = 8;
  localparam int EV_STATE_LSB = 9;
  localparam logic [4:0] BP_RST = 5'h00;
  localparam logic [1:0] LOCK_RST = 2'h0;
  localparam logic [18:0] ARRAY_BYTES = 19'h40000;
  localparam logic [18:0] SZ_4K = 19'h01000;
  localparam logic [18:0] SZ_8K = 19'h02000;
  localparam logic [18:0] SZ_16K = 19'h04000;
  localparam logic [18:0] SZ_32K = 19'h08000;
  localparam logic [18:0] SZ_64K = 19'h10000;
  localparam logic [18:0] SZ_128K = 19'h20000;
  localparam logic [ADDR_W-1:0] SPAN_PAGE = 18'h000ff;
  localparam logic [ADDR_W-1:0] SPAN_SECT = 18'h00fff;
  localparam logic [ADDR_W-1:0] SPAN_32K = 18'h07fff;
  localparam logic [ADDR_W-1:0] SPAN_64K = 18'h0ffff;
  localparam logic [ADDR_W-1:0] SPAN_CHIP = 18'h3ffff;
  typedef enum logic [3:0] {
    CMD_WEN = 4'h0, CMD_WDIS = 4'h1, CMD_PROG = 4'h2, CMD_ER_PAGE = 4'h3,
    CMD_ER_SECT = 4'h4, CMD_ER_32K = 4'h5, CMD_ER_64K = 4'h6, CMD_ER_CHIP = 4'h7,
    CMD_SUSP = 4'h8, CMD_RESUME = 4'h9, CMD_DPD = 4'ha, CMD_WAKE = 4'hb
  } fwpt_cmd_e;
  typedef enum logic [2:0] {
    S_STANDBY = 3'h0, S_BUSY = 3'h1, S_SUSPENDING = 3'h2, S_SUSPENDED = 3'h3, S_POWERDOWN = 3'h4
  } fwpt_state_e;
  typedef struct packed {
    logic valid;
    fwpt_cmd_e op;
    logic [ADDR_W-1:0] addr;
    logic [11:0] nbits;
  } fwpt_cmd_s;
  typedef struct packed {
    logic go;
    logic run;
    logic erase;
    logic [ADDR_W-1:0] lo;
    logic [ADDR_W-1:0] hi;
  } fwpt_arr_s;
endpackage

//--- src/fwpt_core.sv
// Overview of operation
// - Suspend completes within 30 us
// - Page program finishes within 3 ms
// - Every erase finishes within 20 ms
// - Power-up returns control to standby
// - Delivered status reads zero, array erased
// - Act only on whole-byte command lengths
// - Data changes need write enable latch set
// - Protect bits select read-only region
// - Guard pin low locks protect, lock bits
// - Deep power-down ignores all but wake
// - Plain large-region protect decode
// - Plain fine-grained protect decode
// - Invert bit complements protected region
`timescale 1ns/1ns
`default_nettype none
module fwpt_core
  import fwpt_pkg::*;
#(
  parameter int PROG_CYCLES = PROG_TYP_CYC,
  parameter int ERASE_CYCLES = ERASE_TYP_CYC
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire fwpt_cmd_s cmd,
  input wire logic wr_guard_n,
  input wire logic [REG_AW-1:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  output fwpt_arr_s arr_req
);
  if (PROG_CYCLES < 1 || PROG_CYCLES > PROG_MAX_CYC) begin : g_prog_chk
    $error("PROG_CYCLES out of range");
  end
  if (ERASE_CYCLES < 1 || ERASE_CYCLES > ERASE_MAX_CYC) begin : g_erase_chk
    $error("ERASE_CYCLES out of range");
  end

  fwpt_state_e st_q, st_d;
  logic write_enable_latch_q, write_enable_latch_d;
  logic [4:0] protect_range_bits_q, protect_range_bits_d;
  logic [1:0] status_lock_bits_q, status_lock_bits_d;
  logic range_invert_bit_q, range_invert_bit_d;
  logic [17:0] op_cnt_q, op_cnt_d;
  logic [8:0] sus_cnt_q, sus_cnt_d;
  logic [8:0] space_cnt_q, space_cnt_d;
  logic [9:0] pwr_cnt_q, pwr_cnt_d;
  logic ready_q, ready_d;
  logic [4:0] ev_q, ev_d;
  fwpt_arr_s arr_q, arr_d;
  logic [31:0] rdata_q, rdata_d;

  logic [18:0] psz;
  logic ptop;
  logic [18:0] plo, phi;
  logic [ADDR_W-1:0] span;
  logic [18:0] op_lo, op_hi;
  logic hit;
  logic len_ok;
  logic is_write_op;
  logic [4:0] ev_set;
  logic [15:0] status_word;

  // Spacing counter runs down only in busy time after a resume
  // Power-up counter drops commands until it expires

  // Protected region as size plus side, so the invert is a plain subtraction
  always_comb begin
    psz = '0;
    if (!protect_range_bits_q[4]) begin
      unique case (protect_range_bits_q[1:0])
        2'h0: psz = '0;
        2'h1: psz = SZ_64K;
        2'h2: psz = SZ_128K;
        2'h3: psz = ARRAY_BYTES;
      endcase
    end else begin
      unique case (protect_range_bits_q[2:0])
        3'h0: psz = '0;
        3'h1: psz = SZ_4K;
        3'h2: psz = SZ_8K;
        3'h3: psz = SZ_16K;
        3'h7: psz = ARRAY_BYTES;
        default: psz = SZ_32K;
      endcase
    end
    ptop = !protect_range_bits_q[3];
    if (range_invert_bit_q) begin
      psz = ARRAY_BYTES - psz;
      ptop = !ptop;
    end
    if (ptop) begin
      plo = ARRAY_BYTES - psz;
      phi = ARRAY_BYTES - 19'h00001;
    end else begin
      plo = '0;
      phi = psz - 19'h00001;
    end
  end


  // Footprint is the aligned span around the address
  // A partial overlap refuses the whole operation
  always_comb begin
    unique case (cmd.op)
      CMD_ER_SECT: span = SPAN_SECT;
      CMD_ER_32K: span = SPAN_32K;
      CMD_ER_64K: span = SPAN_64K;
      CMD_ER_CHIP: span = SPAN_CHIP;
      default: span = SPAN_PAGE;
    endcase
    op_lo = {1'b0, cmd.addr & ~span};
    op_hi = {1'b0, cmd.addr | span};
    hit = (psz != '0) && (op_lo <= phi) && (op_hi >= plo);
    len_ok = (cmd.nbits[2:0] == 3'h0) && (cmd.nbits != '0);
    is_write_op = (cmd.op >= CMD_PROG) && (cmd.op <= CMD_ER_CHIP);
  end


  // One next-state process for control state and counters
  always_comb begin
    st_d = st_q;
    write_enable_latch_d = write_enable_latch_q;
    protect_range_bits_d = protect_range_bits_q;
    status_lock_bits_d = status_lock_bits_q;
    range_invert_bit_d = range_invert_bit_q;
    op_cnt_d = op_cnt_q;
    sus_cnt_d = sus_cnt_q;
    space_cnt_d = space_cnt_q;
    pwr_cnt_d = pwr_cnt_q;
    ready_d = ready_q;
    arr_d = arr_q;
    arr_d.go = 1'b0;
    ev_set = '0;
    // Select before the power settle time has passed is dropped
    if (!ready_q) begin
      pwr_cnt_d = pwr_cnt_q + 10'h001;
      ready_d = (pwr_cnt_q == 10'(VSL_CYC - 1));
      ev_set[4] = cmd.valid;
    end
    if (space_cnt_q != '0 && st_q == S_BUSY) begin
      space_cnt_d = space_cnt_q - 9'h001;
    end
    if (cmd.valid && ready_q && !len_ok) begin
      ev_set[0] = 1'b1;
    end
    unique case (st_q)
      S_STANDBY: begin
        if (cmd.valid && ready_q && len_ok) begin
          unique case (cmd.op)
            CMD_WEN: write_enable_latch_d = 1'b1;
            CMD_WDIS: write_enable_latch_d = 1'b0;
            CMD_DPD: st_d = S_POWERDOWN;
            default: begin
              if (is_write_op) begin
                if (!write_enable_latch_q) begin
                  ev_set[1] = 1'b1;
                end else if (hit) begin
                  ev_set[2] = 1'b1;
                  write_enable_latch_d = 1'b0;
                end else begin
                  st_d = S_BUSY;
                  arr_d.go = 1'b1;
                  arr_d.erase = (cmd.op != CMD_PROG);
                  arr_d.lo = op_lo[ADDR_W-1:0];
                  arr_d.hi = op_hi[ADDR_W-1:0];
                  // Page program any erase
                  op_cnt_d = (cmd.op == CMD_PROG) ? 18'(PROG_CYCLES) : 18'(ERASE_CYCLES);
                  space_cnt_d = '0;
                end
              end
            end
          endcase
        end else if (!cmd.valid && reg_wr && reg_addr == REG_STATUS_OFS && ready_q) begin
          if (!write_enable_latch_q) begin
            ev_set[1] = 1'b1;
          end else begin
            if (wr_guard_n) begin
              protect_range_bits_d = reg_wdata[ST_BP_LSB +: 5];
              status_lock_bits_d = reg_wdata[ST_LOCK_LSB +: 2];
            end
            // Invert bit is not pin-locked
            range_invert_bit_d = reg_wdata[ST_CMP_BIT];
            write_enable_latch_d = 1'b0;
          end
        end
      end
      S_BUSY: begin
        op_cnt_d = op_cnt_q - 18'h00001;
        if (op_cnt_q == 18'h00001) begin
          st_d = S_STANDBY;
          write_enable_latch_d = 1'b0;
        end else if (cmd.valid && ready_q && len_ok && cmd.op == CMD_SUSP) begin
          // Early suspend is refused so the operation still progresses
          if (space_cnt_q != '0) begin
            ev_set[3] = 1'b1;
          end else begin
            st_d = S_SUSPENDING;
            sus_cnt_d = 9'(SUSP_LAT_CYC - 1);
          end
        end
      end
      S_SUSPENDING: begin
        // Operation counter frozen while suspend settles
        sus_cnt_d = sus_cnt_q - 9'h001;
        if (sus_cnt_q == '0) begin
          st_d = S_SUSPENDED;
        end
      end
      S_SUSPENDED: begin
        // Latch may still be toggled while suspended
        if (cmd.valid && ready_q && len_ok) begin
          if (cmd.op == CMD_RESUME) begin
            st_d = S_BUSY;
            space_cnt_d = 9'(RES_SUSP_CYC);
          end else if (cmd.op == CMD_WEN) begin
            write_enable_latch_d = 1'b1;
          end else if (cmd.op == CMD_WDIS) begin
            write_enable_latch_d = 1'b0;
          end
        end
      end
      S_POWERDOWN: begin
        // Only wake is decoded, the rest fall away
        if (cmd.valid && ready_q && len_ok && cmd.op == CMD_WAKE) begin
          st_d = S_STANDBY;
        end
      end
      default: st_d = S_STANDBY;
    endcase
    arr_d.run = (st_d == S_BUSY);
    // New events win over a clear in the same cycle
    ev_d = ev_q | ev_set;
    if (reg_wr && reg_addr == REG_EVENT_OFS) begin
      ev_d = (ev_q & ~reg_wdata[4:0]) | ev_set;
    end
  end


  // Suspend latency still reads busy so the host keeps polling
  always_comb begin
    status_word = '0;
    status_word[ST_BUSY_BIT] = (st_q == S_BUSY) || (st_q == S_SUSPENDING);
    status_word[ST_WEL_BIT] = write_enable_latch_q;
    status_word[ST_BP_LSB +: 5] = protect_range_bits_q;
    status_word[ST_LOCK_LSB +: 2] = status_lock_bits_q;
    status_word[ST_CMP_BIT] = range_invert_bit_q;
    status_word[ST_SUS_BIT] = (st_q == S_SUSPENDED);
    rdata_d = '0;
    if (reg_rd) begin
      if (reg_addr == REG_STATUS_OFS) begin
        rdata_d = {16'h0000, status_word};
      end else if (reg_addr == REG_EVENT_OFS) begin
        rdata_d = {20'h00000, st_q, ready_q, 3'h0, ev_q};
      end
    end
  end


  // Power-up reset puts the controller back in standby
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= S_STANDBY;
      write_enable_latch_q <= 1'b0;
      protect_range_bits_q <= BP_RST;
      status_lock_bits_q <= LOCK_RST;
      range_invert_bit_q <= 1'b0;
      op_cnt_q <= '0;
      sus_cnt_q <= '0;
      space_cnt_q <= '0;
      pwr_cnt_q <= '0;
      ready_q <= 1'b0;
      ev_q <= '0;
      arr_q <= '0;
      rdata_q <= '0;
    end else begin
      st_q <= st_d;
      write_enable_latch_q <= write_enable_latch_d;
      protect_range_bits_q <= protect_range_bits_d;
      status_lock_bits_q <= status_lock_bits_d;
      range_invert_bit_q <= range_invert_bit_d;
      op_cnt_q <= op_cnt_d;
      sus_cnt_q <= sus_cnt_d;
      space_cnt_q <= space_cnt_d;
      pwr_cnt_q <= pwr_cnt_d;
      ready_q <= ready_d;
      ev_q <= ev_d;
      arr_q <= arr_d;
      rdata_q <= rdata_d;
    end
  end

  assign reg_rdata = rdata_q;
  assign arr_req = arr_q;
endmodule // fwpt_core
`default_nettype wire

//--- testbench/fwpt_core_sva.sv
`timescale 1ns/1ns
`default_nettype none
module fwpt_core_sva
  import fwpt_pkg::*;
#(
  parameter int PROG_CYCLES = PROG_TYP_CYC,
  parameter int ERASE_CYCLES = ERASE_TYP_CYC
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire fwpt_cmd_s cmd,
  input wire logic wr_guard_n,
  input wire logic [REG_AW-1:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire fwpt_arr_s arr_req
);
  logic [31:0] run_q;
  logic [9:0] up_q;
  // Only run cycles count, so suspend time is excluded
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      run_q <= 32'h0;
      up_q <= 10'h0;
    end else begin
      run_q <= arr_req.go ? 32'h1 : (arr_req.run ? run_q + 32'h1 : run_q);
      up_q <= (up_q == 10'h3ff) ? up_q : up_q + 10'h1;
    end
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  sequence s_no_read;
    !reg_rd ##1 1'b1;
  endsequence
  property p_go_run; arr_req.go |-> arr_req.run; endproperty
  a_go_run: assert property (p_go_run) else $error("go without run");
  property p_rd_idle; s_no_read |-> reg_rdata == 32'h0; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data outside slot");
  property p_prog_len; arr_req.run && !arr_req.go && !arr_req.erase |-> run_q < PROG_CYCLES; endproperty
  a_prog_len: assert property (p_prog_len) else $error("program too long");
  property p_erase_len; arr_req.run && !arr_req.go && arr_req.erase |-> run_q < ERASE_CYCLES; endproperty
  a_erase_len: assert property (p_erase_len) else $error("erase too long");
  property p_go_cause;
    arr_req.go |-> $past(cmd.valid && cmd.nbits != 12'h0 && cmd.nbits[2:0] == 3'h0);
  endproperty
  a_go_cause: assert property (p_go_cause) else $error("go without whole-byte command");
  property p_prog_page;
    arr_req.go && !arr_req.erase |-> arr_req.lo == {$past(cmd.addr[17:8]), 8'h00} && arr_req.hi == (arr_req.lo | SPAN_PAGE);
  endproperty
  a_prog_page: assert property (p_prog_page) else $error("program range wrong");
  property p_op_kind; arr_req.go |-> arr_req.erase == ($past(cmd.op) != CMD_PROG); endproperty
  a_op_kind: assert property (p_op_kind) else $error("operation kind wrong");
  property p_no_early; arr_req.go |-> up_q >= 10'h2bb; endproperty
  a_no_early: assert property (p_no_early) else $error("operation before ready");
endmodule // fwpt_core_sva
bind fwpt_core fwpt_core_sva #(.PROG_CYCLES(PROG_CYCLES), .ERASE_CYCLES(ERASE_CYCLES)) fwpt_core_sva_i (
  .clock(clock), .rst_n(rst_n), .cmd(cmd), .wr_guard_n(wr_guard_n), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .arr_req(arr_req));
`default_nettype wire

//--- testbench/fwpt_host.sv
`timescale 1ns/1ns
`default_nettype none
module fwpt_host
  import fwpt_pkg::*;
(
  input wire logic clock,
  input wire logic rst_n,
  input wire fwpt_cmd_s want,
  output var fwpt_cmd_s cmd
);
  logic [9:0] up_q;
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      up_q <= 10'h0;
      cmd <= '0;
    end else begin
      up_q <= (up_q == 10'h3ff) ? up_q : up_q + 10'h1;
      // Select held off until just past the power-up wait
      cmd <= (up_q > 10'h2c0) ? want : '0;
    end
  end
endmodule // fwpt_host
`default_nettype wire

//--- testbench/tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  import fwpt_pkg::*;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic wr_guard_n = 1'b1;
  logic [REG_AW-1:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  logic [31:0] d;
  fwpt_cmd_s want = '0;
  fwpt_cmd_s cmd;
  fwpt_arr_s arr_req;
  int n_fail = 0;
  int checked = 0;
  int n_go = 0;
  int g;
  int i;
  always #50 clock = ~clock;
  always @(posedge clock) if (arr_req.go === 1'b1) n_go <= n_go + 1;
  fwpt_host fwpt_host_i (.clock(clock), .rst_n(rst_n), .want(want), .cmd(cmd));
  fwpt_core #(.PROG_CYCLES(20), .ERASE_CYCLES(40)) fwpt_core_i (.clock(clock), .rst_n(rst_n), .cmd(cmd),
    .wr_guard_n(wr_guard_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .arr_req(arr_req));
  task automatic close_out;
    $display("checks %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD %s exp %h got %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clock);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  task automatic send(input fwpt_cmd_e op, input logic [17:0] a, input logic [11:0] nb);
    @(posedge clock);
    want <= '{1'b1, op, a, nb};
    @(posedge clock);
    want <= '0;
    repeat (3) @(posedge clock);
  endtask
  task automatic wait_idle(input int lim);
    int k;
    for (k = 0; k < lim && arr_req.run !== 1'b0; k++) @(posedge clock);
    if (k == lim) begin
      n_fail++;
      $display("BAD idle exp 0 got 1");
      close_out();
    end
  endtask
  task automatic t_prot(input logic [4:0] bp, input logic cmp, input logic [17:0] a, input logic exp);
    int h;
    send(CMD_WEN, a, 12'h008);
    wr(REG_STATUS_OFS, {22'h0, cmp, 2'h0, bp, 2'h0});
    send(CMD_WEN, a, 12'h008);
    h = n_go;
    send(CMD_ER_SECT, a, 12'h020);
    chk("erase go", {31'h0, exp}, 32'(n_go - h));
    wait_idle(60);
    rd(REG_STATUS_OFS);
    chk("latch", 32'h0, {31'h0, d[1]});
  endtask
  initial begin
    repeat (5) @(posedge clock);
    rst_n <= 1'b1;
    rd(REG_STATUS_OFS);
    chk("status", 32'h0, d);
    rd(REG_EVENT_OFS);
    chk("state", 32'h0, {29'h0, d[11:9]});
    repeat (710) @(posedge clock);
    rd(REG_EVENT_OFS);
    chk("ready", 32'h1, {31'h0, d[8]});
    $display("done reset");
    g = n_go;
    send(CMD_PROG, 18'h01234, 12'h820);
    chk("go no latch", 32'h0, 32'(n_go - g));
    rd(REG_EVENT_OFS);
    chk("no latch ev", 32'h1, {31'h0, d[1]});
    send(CMD_WEN, 18'h0, 12'h008);
    rd(REG_STATUS_OFS);
    chk("latch set", 32'h1, {31'h0, d[1]});
    g = n_go;
    send(CMD_PROG, 18'h01234, 12'h820);
    chk("prog go", 32'h1, 32'(n_go - g));
    chk("prog lo", 32'h01200, {14'h0, arr_req.lo});
    wait_idle(25);
    send(CMD_WEN, 18'h0, 12'h007);
    rd(REG_STATUS_OFS);
    chk("bad length", 32'h0, {31'h0, d[1]});
    $display("done program");
    t_prot(5'h00, 1'b0, 18'h30000, 1'b1);
    t_prot(5'h01, 1'b0, 18'h30000, 1'b0);
    t_prot(5'h01, 1'b0, 18'h20000, 1'b1);
    t_prot(5'h02, 1'b0, 18'h20000, 1'b0);
    t_prot(5'h09, 1'b0, 18'h00000, 1'b0);
    t_prot(5'h09, 1'b0, 18'h10000, 1'b1);
    t_prot(5'h03, 1'b0, 18'h10000, 1'b0);
    t_prot(5'h11, 1'b0, 18'h3f000, 1'b0);
    t_prot(5'h11, 1'b0, 18'h3e000, 1'b1);
    t_prot(5'h1c, 1'b0, 18'h07000, 1'b0);
    t_prot(5'h1c, 1'b0, 18'h08000, 1'b1);
    t_prot(5'h17, 1'b0, 18'h00000, 1'b0);
    t_prot(5'h01, 1'b1, 18'h20000, 1'b0);
    t_prot(5'h01, 1'b1, 18'h30000, 1'b1);
    t_prot(5'h03, 1'b1, 18'h00000, 1'b1);
    t_prot(5'h00, 1'b1, 18'h00000, 1'b0);
    $display("done protect");
    send(CMD_WEN, 18'h0, 12'h008);
    wr(REG_STATUS_OFS, 32'h0);
    @(posedge clock);
    wr_guard_n <= 1'b0;
    send(CMD_WEN, 18'h0, 12'h008);
    wr(REG_STATUS_OFS, 32'h0000000c);
    rd(REG_STATUS_OFS);
    chk("guarded status", 32'h0, d);
    @(posedge clock);
    wr_guard_n <= 1'b1;
    $display("done guard");
    send(CMD_WEN, 18'h0, 12'h008);
    send(CMD_ER_SECT, 18'h00000, 12'h020);
    send(CMD_SUSP, 18'h0, 12'h008);
    for (i = 0; i < 170; i++) begin
      rd(REG_STATUS_OFS);
      if (d[10] === 1'b1) break;
    end
    chk("suspended", 32'h1, {31'h0, d[10]});
    chk("run held", 32'h0, {31'h0, arr_req.run});
    send(CMD_RESUME, 18'h0, 12'h008);
    send(CMD_SUSP, 18'h0, 12'h008);
    rd(REG_EVENT_OFS);
    chk("early suspend", 32'h1, {31'h0, d[3]});
    wait_idle(60);
    $display("done suspend");
    send(CMD_DPD, 18'h0, 12'h008);
    send(CMD_WEN, 18'h0, 12'h008);
    rd(REG_STATUS_OFS);
    chk("asleep latch", 32'h0, {31'h0, d[1]});
    rd(REG_EVENT_OFS);
    chk("asleep state", 32'h4, {29'h0, d[11:9]});
    send(CMD_WAKE, 18'h0, 12'h008);
    send(CMD_WEN, 18'h0, 12'h008);
    rd(REG_STATUS_OFS);
    chk("awake latch", 32'h1, {31'h0, d[1]});
    $display("done powerdown");
    close_out();
  end
endmodule // tb_top
`default_nettype wire
